// ### rtl/spimsp_buf2.v
`timescale 1ns/1ns
module spimsp_buf2 #(
    parameter WIDTH = 8
) (
    input  wire             core_clk_i,
    input  wire             resetn_i,
    input  wire             ce_i,
    input  wire             flush_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem0;
    reg [WIDTH-1:0] mem1;
    reg [1:0]       count;
    wire push = in_valid_i & (count != 2'd2);
    wire pop  = out_ready_i & (count != 2'd0);

    assign in_ready_o  = (count != 2'd2);
    assign out_valid_o = (count != 2'd0);
    assign out_data_o  = mem0;

    // ------------------------------------------------
    // Two-entry storage; head is always mem0
    // ------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!resetn_i || (ce_i && flush_i)) begin
            count <= 2'd0;
            mem0  <= {WIDTH{1'b0}};
            mem1  <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'd0) mem0 <= in_data_i;
                    else mem1 <= in_data_i;
                    count <= count + 2'd1;
                end
                2'b01: begin
                    mem0  <= mem1;
                    count <= count - 2'd1;
                end
                2'b11: begin
                    if (count == 2'd1) mem0 <= in_data_i;
                    else begin
                        mem0 <= mem1;
                        mem1 <= in_data_i;
                    end
                end
                default: ;
            endcase
        end
    end
endmodule

// ### rtl/spimsp_defs.vh
`ifndef SPIMSP_DEFS_VH
`define SPIMSP_DEFS_VH
`define SPIMSP_M_DIV4     4'h0
`define SPIMSP_M_DIV16    4'h1
`define SPIMSP_M_DIV64    4'h2
`define SPIMSP_M_RELOAD   4'h3
`define SPIMSP_S_SEL      4'h4
`define SPIMSP_S_PLAIN    4'h5
`define SPIMSP_HALF4      8'h01
`define SPIMSP_HALF16     8'h07
`define SPIMSP_HALF64     8'h1f
`define SPIMSP_ST_WMASK   8'hc0
`define SPIMSP_ST_BF      0
`define SPIMSP_ST_SMP     7
`define SPIMSP_ST_CKE     6
`define SPIMSP_C1_WRITE_COLLISION_FLAG    7
`define SPIMSP_C1_OV      6
`define SPIMSP_C1_EN      5
`define SPIMSP_C1_CKP     4
`define SPIMSP_C3_BUFFER_OVERWRITE_ENABLE    4
`define SPIMSP_BITS       4'h8
`endif

// ### rtl/spimsp_port.v
`timescale 1ns/1ns
`include "spimsp_defs.vh"
module spimsp_port (
    input  wire       core_clk_i,
    input  wire       resetn_i,
    input  wire       ce_i,
    input  wire [7:0] ctl1_wdata_i,
    input  wire       ctl1_we_i,
    input  wire [7:0] ctl3_wdata_i,
    input  wire       ctl3_we_i,
    input  wire [7:0] stat_wdata_i,
    input  wire       stat_we_i,
    input  wire [7:0] reload_wdata_i,
    input  wire       reload_we_i,
    input  wire [7:0] buf_wdata_i,
    input  wire       buf_we_i,
    input  wire       buf_re_i,
    input  wire       sdi_i,
    input  wire       sck_i,
    input  wire       ss_n_i,
    output reg  [7:0] port_control_one_o,
    output reg  [7:0] port_control_three_o,
    output reg  [7:0] port_status_reg_o,
    output reg  [7:0] data_buffer_o,
    output reg        transfer_done_flag_o,
    output reg        sdo_o,
    output reg        sdo_oe_o,
    output reg        sck_o,
    output reg        sck_oe_o,
    output reg        pins_claimed_o
);
    // ------------------------------------------------
    // State
    // ------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_LEAD = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg  [7:0] rate_reload_value;
    reg  [7:0] shift_register;
    reg  [3:0] bit_cnt;
    reg  [2:0] state;
    reg  [7:0] div_cnt;
    reg        phase;
    reg        in_bit;
    reg        sck_prev;
    reg        rx_valid;
    reg  [7:0] rx_byte;
    reg  [7:0] half_div;

    wire [3:0] mode  = port_control_one_o[3:0];
    wire       en    = port_control_one_o[`SPIMSP_C1_EN];
    wire       clock_idle_polarity   = port_control_one_o[`SPIMSP_C1_CKP];
    wire       write_collision_flag  = port_control_one_o[`SPIMSP_C1_WRITE_COLLISION_FLAG];
    wire       cke   = port_status_reg_o[`SPIMSP_ST_CKE];
    wire       input_sample_phase   = port_status_reg_o[`SPIMSP_ST_SMP];
    wire       bf    = port_status_reg_o[`SPIMSP_ST_BF];
    wire       buffer_overwrite_enable  = port_control_three_o[`SPIMSP_C3_BUFFER_OVERWRITE_ENABLE];
    wire       master = (mode == `SPIMSP_M_DIV4) | (mode == `SPIMSP_M_DIV16)
                      | (mode == `SPIMSP_M_DIV64)
                      | (mode == `SPIMSP_M_RELOAD);
    wire       ss_mode = (mode == `SPIMSP_S_SEL);
    wire       ss_off  = ss_mode & ss_n_i;
    wire       port_rst = ~en | ss_off;
    wire       busy     = (bit_cnt != 4'h0) | (state != ST_IDLE);
    wire       buf_ok   = ~busy & ~write_collision_flag & (~bf | buffer_overwrite_enable);
    wire       load     = en & buf_we_i & buf_ok;
    wire       coll     = en & buf_we_i & ~buf_ok & busy;

    // Slave edges from the synchronous clock pin
    wire sck_rise  = sck_i & ~sck_prev;
    wire sck_fall  = ~sck_i & sck_prev;
    wire lead_edge = clock_idle_polarity ? sck_fall : sck_rise;
    wire trail_edge = clock_idle_polarity ? sck_rise : sck_fall;
    // Edge bit set: data out leads, so input is taken on the leading edge
    wire s_sample  = cke ? lead_edge : trail_edge;
    wire s_shift   = cke ? trail_edge : lead_edge;

    wire tick      = (div_cnt == half_div);
    wire m_last    = (bit_cnt == `SPIMSP_BITS) & phase;
    wire s_last    = ~master & s_sample & (bit_cnt == 4'h7);
    wire byte_done = (master ? (state == ST_RUN & tick & m_last)
                             : s_last) & en & ~ss_off;

    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg  [7:0] rx_next;
    reg        drain;

    // ------------------------------------------------
    // Rate select
    // ------------------------------------------------
    always @* begin
        case (mode)
            `SPIMSP_M_DIV4:   half_div = `SPIMSP_HALF4;
            `SPIMSP_M_DIV16:  half_div = `SPIMSP_HALF16;
            `SPIMSP_M_DIV64:  half_div = `SPIMSP_HALF64;
            default: half_div = {rate_reload_value[6:0], 1'b1};
        endcase
    end

    always @* begin
        // Master samples mid bit or at end per phase bit
        rx_next = {shift_register[6:0], in_bit};
        drain = ~bf | buffer_overwrite_enable;
    end

    // ------------------------------------------------
    // Register file
    // ------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!resetn_i) begin
            port_control_one_o   <= 8'h00;
            port_control_three_o <= 8'h00;
            port_status_reg_o    <= 8'h00;
            rate_reload_value    <= 8'h00;
            data_buffer_o        <= 8'h00;
            transfer_done_flag_o <= 1'b0;
            pins_claimed_o       <= 1'b0;
        end else if (ce_i) begin
            pins_claimed_o <= en;
            if (ctl1_we_i)
                port_control_one_o <= ctl1_wdata_i;
            if (coll)
                port_control_one_o[`SPIMSP_C1_WRITE_COLLISION_FLAG] <= 1'b1;
            if (ctl3_we_i)
                port_control_three_o <= ctl3_wdata_i;
            if (stat_we_i)
                port_status_reg_o <= (stat_wdata_i & `SPIMSP_ST_WMASK)
                    | (port_status_reg_o & ~`SPIMSP_ST_WMASK);
            if (reload_we_i)
                rate_reload_value <= reload_wdata_i;
            if (buf_re_i)
                port_status_reg_o[`SPIMSP_ST_BF] <= 1'b0;
            transfer_done_flag_o <= 1'b0;
            if (load)
                data_buffer_o <= buf_wdata_i;
            else if (fifo_out_valid && drain) begin
                data_buffer_o <= fifo_out_data;
                port_status_reg_o[`SPIMSP_ST_BF] <= 1'b1;
                transfer_done_flag_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------
    // Shift engine
    // ------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!resetn_i) begin
            shift_register <= 8'h00;
            bit_cnt  <= 4'h0;
            state    <= ST_IDLE;
            div_cnt  <= 8'h00;
            phase    <= 1'b0;
            in_bit   <= 1'b0;
            sck_prev <= 1'b0;
            sck_o    <= 1'b0;
            sck_oe_o <= 1'b0;
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else if (ce_i) begin
            sck_prev <= sck_i;
            sck_oe_o <= en & master;
            sdo_oe_o <= en & ~ss_off;
            sdo_o    <= shift_register[7];
            if (fifo_in_ready)
                rx_valid <= 1'b0;
            if (port_rst) begin
                bit_cnt <= 4'h0;
                state   <= ST_IDLE;
                div_cnt <= 8'h00;
                phase   <= 1'b0;
                sck_o   <= clock_idle_polarity;
            end else if (load) begin
                shift_register <= buf_wdata_i;
                div_cnt <= 8'h00;
                phase   <= 1'b0;
                bit_cnt <= master ? 4'h0 : bit_cnt;
                state   <= master ? (cke ? ST_RUN : ST_LEAD) : ST_IDLE;
                sck_o   <= clock_idle_polarity;
            end else if (master) begin
                // Idle level follows polarity bit changed while enabled
                if (state == ST_IDLE)
                    sck_o <= clock_idle_polarity;
                // A full two-entry receive buffer or a pending byte stops the clock before overrun
                if (state != ST_IDLE && fifo_in_ready && !rx_valid) begin
                    div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
                    if (tick) begin
                        case (state)
                            ST_LEAD: begin
                                sck_o   <= ~sck_o;
                                state   <= ST_RUN;
                                bit_cnt <= 4'h1;
                                phase   <= 1'b1;
                                if (!input_sample_phase) in_bit <= sdi_i;
                            end
                            ST_RUN: begin
                                if (m_last) begin
                                    state   <= ST_IDLE;
                                    bit_cnt <= 4'h0;
                                    sck_o   <= clock_idle_polarity;
                                    if (input_sample_phase) in_bit <= sdi_i;
                                    rx_byte <= {shift_register[6:0],
                                                input_sample_phase ? sdi_i : in_bit};
                                    rx_valid <= 1'b1;
                                end else begin
                                    sck_o <= ~sck_o;
                                    phase <= ~phase;
                                    if (!phase) begin
                                        bit_cnt <= bit_cnt + 4'h1;
                                        if (!input_sample_phase) in_bit <= sdi_i;
                                    end else begin
                                        if (input_sample_phase) in_bit <= sdi_i;
                                        shift_register <= input_sample_phase
                                            ? {shift_register[6:0], sdi_i}
                                            : rx_next;
                                    end
                                end
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
            end else begin
                // Slave: external clock edges, taken only while ce_i is high
                if (s_sample) begin
                    shift_register <= {shift_register[6:0], sdi_i};
                    if (bit_cnt == 4'h7) begin
                        bit_cnt  <= 4'h0;
                        rx_byte  <= {shift_register[6:0], sdi_i};
                        rx_valid <= 1'b1;
                    end else
                        bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end

    spimsp_buf2 #(
        .WIDTH(8)
    ) u_rxbuf (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .flush_i     (~en),
        .in_valid_i  (rx_valid & ~byte_done),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rx_byte),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (drain & ~load),
        .out_data_o  (fifo_out_data)
    );
endmodule

// ### tb/spimsp_peer.sv
`timescale 1ns/1ns
module spimsp_peer (
    input  wire       sck_i,
    input  wire       pol_i,
    input  wire       mosi_i,
    input  wire       load_i,
    input  wire [7:0] reply_i,
    output wire       miso_o,
    output reg  [7:0] sr_o
);
    reg  samp;
    // Active edge follows the idle level, so polarity needs no mode logic
    wire act = sck_i ^ pol_i;
    assign miso_o = sr_o[7];
    always @(posedge load_i) sr_o = reply_i;
    always @(posedge act) samp = mosi_i;
    always @(negedge act) sr_o = {sr_o[6:0], samp};
endmodule

// ### tb/spimsp_port_tb_top.sv
`timescale 1ns/1ns
module spimsp_port_tb_top;
    localparam [7:0] RL = 8'h02;
    reg        core_clk_i = 1'b0;
    reg        resetn_i = 1'b0;
    reg  [7:0] wd = 8'h00;
    reg  [4:0] we = 5'h00;
    reg        buf_re = 1'b0;
    reg        tsck = 1'b0;
    reg        tsdi = 1'b0;
    reg        ss_n = 1'b1;
    reg        slv = 1'b0;
    reg        pl = 1'b0;
    reg  [7:0] rep = 8'h00;
    reg        sdo_q = 1'b0;
    reg        sck_q = 1'b0;
    wire [7:0] c1, c3, st, db, prx;
    wire       done, sdo, sdo_oe, sck, sck_oe, clm, psdi;
    // Released data line shows the inverse of its last value
    wire       sdo_w = sdo_oe ? sdo : ~sdo_q;
    wire       sck_w = sck_oe ? sck : tsck;
    integer    error_cnt = 0, num_checks = 0, dones = 0, want = 0;
    integer    cnt = 0, gap = 0, i, t;
    integer    gaps [0:3] = '{2, 8, 32, 2 * (RL + 1)};
    spimsp_port DUT (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .ctl1_wdata_i(wd), .ctl1_we_i(we[0]), .ctl3_wdata_i(wd),
        .ctl3_we_i(we[1]), .stat_wdata_i(wd), .stat_we_i(we[2]),
        .reload_wdata_i(wd), .reload_we_i(we[3]), .buf_wdata_i(wd),
        .buf_we_i(we[4]), .buf_re_i(buf_re), .sdi_i(slv ? tsdi : psdi),
        .sck_i(sck_w), .ss_n_i(ss_n), .port_control_one_o(c1),
        .port_control_three_o(c3), .port_status_reg_o(st),
        .data_buffer_o(db), .transfer_done_flag_o(done), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .sck_o(sck), .sck_oe_o(sck_oe),
        .pins_claimed_o(clm));
    spimsp_peer u_peer (.sck_i(sck_w), .pol_i(c1[4]), .mosi_i(sdo_w),
        .load_i(pl), .reply_i(rep), .miso_o(psdi), .sr_o(prx));
    initial forever #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        sck_q <= sck;
        if (sdo_oe) sdo_q <= sdo;
        if (done === 1'b1) dones <= dones + 1;
        if (sck !== sck_q) begin
            gap <= cnt;
            cnt <= 1;
        end else cnt <= cnt + 1;
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task check(input [63:0] seen, input [63:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task wr(input integer k, input [7:0] d);
        @(posedge core_clk_i);
        wd <= d;
        we <= 5'h01 << k;
        @(posedge core_clk_i);
        we <= 5'h00;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    task rd;
        @(posedge core_clk_i);
        buf_re <= 1'b1;
        @(posedge core_clk_i);
        buf_re <= 1'b0;
        tick(2);
        @(negedge core_clk_i);
    endtask
    task wait_done;
        want = want + 1;
        for (t = 0; t < 3000 && dones < want; t = t + 1) tick(1);
        @(negedge core_clk_i);
        check(dones, want);
    endtask
    task load(input [7:0] r);
        rep = r;
        pl = 1'b1;
        #1 pl = 1'b0;
    endtask
    // Control write goes through disable first; status is written while enabled
    task mstr(input [3:0] m, input [7:0] tx, input [7:0] rx, input integer g);
        wr(0, 8'h00);
        wr(0, {3'b001, m[0], m});
        wr(2, 8'h40);
        check(c1, {3'b001, m[0], m});
        check({sck_oe, sck, clm}, {1'b1, m[0], 1'b1});
        load(rx);
        wr(4, tx);
        check(db, tx);
        wait_done;
        check(prx, tx);
        check({st[0], db}, {1'b1, rx});
        check(gap, g);
        rd;
        check(st[0], 1'b0);
    endtask
    task sx(input [7:0] tx, input [7:0] ex, input integer n, input chk);
        reg [7:0] got;
        got = 8'h00;
        for (i = 0; i < n; i = i + 1) begin
            tsdi <= tx[7 - i];
            tick(6);
            got = {got[6:0], sdo_w};
            tsck <= 1'b1;
            tick(6);
            tsck <= 1'b0;
        end
        tick(6);
        if (chk) check(got, ex);
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        tick(10);
        resetn_i <= 1'b1;
        tick(1);
        @(negedge core_clk_i);
        check({c1, c3, st, db, done, clm}, 34'h0);
        wr(0, 8'hd3);
        check(c1, 8'hd3);
        wr(2, 8'hff);
        check(st, 8'hc0);
        wr(0, 8'h00);
        wr(3, RL);
        for (i = 0; i < 4; i = i + 1) mstr(i[3:0], 8'ha5 + i, 8'h3c ^ i, gaps[i]);
        load(8'h77);
        wr(4, 8'hc3);
        wr(4, 8'h3c);
        wait_done;
        check({c1[7], prx}, {1'b1, 8'hc3});
        rd;
        wr(4, 8'h99);
        tick(120);
        check(dones, want);
        check({c1[7], db}, {1'b1, 8'h77});
        wr(0, 8'h33);
        check(c1, 8'h33);
        load(8'h81);
        wr(4, 8'h11);
        wait_done;
        wr(4, 8'h22);
        tick(120);
        check({dones, db}, {want, 8'h81});
        wr(1, 8'h10);
        check(c3, 8'h10);
        load(8'h42);
        wr(4, 8'h22);
        wait_done;
        check(prx, 8'h22);
        rd;
        rd;
        check(st[0], 1'b0);
        wr(1, 8'h00);
        wr(0, 8'h00);
        wr(0, 8'h24);
        check({sck_oe, clm}, 2'b01);
        check(sck_w, c1[4]);
        @(posedge core_clk_i);
        slv <= 1'b1;
        ss_n <= 1'b0;
        wr(4, 8'h6e);
        sx(8'hb1, 8'h6e, 8, 1'b1);
        wait_done;
        check(db, 8'hb1);
        rd;
        sx(8'h47, 8'hb1, 8, 1'b1);
        wait_done;
        check(db, 8'h47);
        rd;
        sx(8'hff, 8'h00, 3, 1'b0);
        ss_n <= 1'b1;
        tick(6);
        check(sdo_oe, 1'b0);
        ss_n <= 1'b0;
        sx(8'h2d, 8'h00, 8, 1'b0);
        wait_done;
        check(db, 8'h2d);
        rd;
        wr(0, 8'h00);
        wr(0, 8'h25);
        check({c1, sck_oe}, {8'h25, 1'b0});
        wr(0, 8'h00);
        check({clm, sdo_oe, sck_oe}, 3'b000);
        summarize;
    end
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule

// ### tb/spimsp_props.sv
`timescale 1ns/1ns
module spimsp_props (
    input wire       core_clk_i,
    input wire       resetn_i,
    input wire       ce_i,
    input wire       ctl1_we_i,
    input wire       stat_we_i,
    input wire [7:0] stat_wdata_i,
    input wire       buf_we_i,
    input wire       buf_re_i,
    input wire       ss_n_i,
    input wire [7:0] port_control_one_o,
    input wire [7:0] port_status_reg_o,
    input wire [7:0] data_buffer_o,
    input wire       transfer_done_flag_o,
    input wire       sdo_oe_o,
    input wire       sck_oe_o,
    input wire       pins_claimed_o
);
    // ------------------------------------------------------------
    // Port rules
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire       en = port_control_one_o[5];
    wire [3:0] md = port_control_one_o[3:0];
    // Outputs may lag the control register by one edge
    sequence cfg_held;
        $stable(port_control_one_o[5:0]) ##1 $stable(port_control_one_o[5:0]);
    endsequence
    sequence sel_off;
        (en && md == 4'h4 && ss_n_i) [*4];
    endsequence
    sequence rd_quiet;
        buf_re_i && ce_i && !transfer_done_flag_o ##1 !transfer_done_flag_o;
    endsequence
    master_drv_a: assert property (cfg_held |-> !en || md > 4'h3 || sck_oe_o)
        else $error("serial clock not driven in master mode");
    slave_in_a: assert property (cfg_held |-> !(en && md[3:1] == 3'b010 && sck_oe_o))
        else $error("serial clock driven in slave mode");
    claim_en_a: assert property (cfg_held |-> pins_claimed_o == en)
        else $error("pin claim differs from enable");
    off_quiet_a: assert property (cfg_held |-> en || !(sdo_oe_o || sck_oe_o))
        else $error("pins driven while disabled");
    stat_wr_a: assert property (stat_we_i && ce_i |=>
        {port_status_reg_o[7:6], 6'h00} == ($past(stat_wdata_i) & 8'hc0)
        && port_status_reg_o[5:1] == 5'h00)
        else $error("status write wrong");
    write_collision_flag_hold_a: assert property (port_control_one_o[7] && !(ctl1_we_i && ce_i) |=> port_control_one_o[7])
        else $error("collision flag dropped by itself");
    wr_block_a: assert property (buf_we_i && ce_i && port_control_one_o[7] |=> $stable(data_buffer_o) || transfer_done_flag_o)
        else $error("buffer write taken with collision flag set");
    done_flag_a: assert property ($rose(transfer_done_flag_o) |-> ##[0:3] port_status_reg_o[0])
        else $error("done without buffer full");
    done_once_a: assert property (transfer_done_flag_o |=> !transfer_done_flag_o)
        else $error("done flag longer than one cycle");
    bf_read_a: assert property (rd_quiet |-> !port_status_reg_o[0])
        else $error("buffer full not cleared by read");
    ss_off_a: assert property (sel_off |-> !sdo_oe_o)
        else $error("data out driven while deselected");
endmodule
bind spimsp_port spimsp_props u_props (.*);
